// [common/ext_mem_map.svh]
`ifndef EXT_MEM_MAP_SVH
`define EXT_MEM_MAP_SVH
// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define STRETCH_CTRL_IDX 8'hFD
`define ADDR_STRETCH_CTRL 12'h3F4
`define ADDR_CORE_MODE 12'h400
`define ADDR_EXT_INT_VEC 12'h404
`define ADDR_SEG_CPU_PROG 12'h408
`define ADDR_SEG_CPU_DATA 12'h40C
`define ADDR_SEG_DMA_PROG 12'h410
`define ADDR_SEG_DMA_DATA 12'h414
`define ADDR_OUT_TIMING 12'h418
`define ADDR_STATUS 12'h41C
// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define STRETCH_CTRL_RESET 8'h7F
`define STRETCH_CTRL_MASK 8'h7F
`define SEG_RESET 8'hFE
`define SEG_IO_VALUE 8'hFF
`define PORT_CFG_ROM 3'h0
`define PORT_CFG_ROMLESS 3'h3
`define BUS_RESUME_CYCLES 2'h2
`endif

// [common/ext_mem_pkg.sv]
package ext_mem_pkg;
    typedef enum logic [2:0] {
        IDLE_ST = 3'h0,
        T2_ST = 3'h1,
        PROG_ST = 3'h2,
        PIN_ST = 3'h3,
        T3_ST = 3'h4,
        FLOAT_ST = 3'h5,
        RESUME_ST = 3'h6
    } cycle_type;
    typedef enum logic [1:0] {
        CPU_PROG = 2'h0,
        CPU_DATA = 2'h1,
        DMA_PROG = 2'h2,
        DMA_DATA = 2'h3
    } access_type;
endpackage

// [src/ext_mem_stretch.sv]
`timescale 1ns/1ps
`include "ext_mem_map.svh"
// Contract
// - On-chip accesses never stretched, run at full core clock rate.
// - Enabled stretch pin sampled once the stretch count runs out; low adds one internal cycle.
// - Pin resampled each added cycle; memory holds it low until ready.
// - Program and data external accesses stretched independently, 0..7.
// - Bits 5:3 give data stretch count in internal clock cycles.
// - Bits 2:0 give program stretch count; zero still adds one cycle.
// - Stretch control resets to 7Fh: both counts seven, watchdog set.
// - Bit 7 of stretch control always reads zero.
// - Bus float bit tristates strobes, R/W, memory ports; internal runs.
// - With program memory, ports reset to weak pull-up, config 000.
// - ROM-less, ports reset to push-pull memory mode, config 011.
// - ROM-less strap caught at reset release; low forces external fetch.
// - Expander drives A23:A16; A15 low selects the common segment.
// - A15 high outputs one of four segment registers by access kind.
// - Expander port shows FEh after reset and while A15 low, except strap 00 gives FFh.
// - Nibble straps captured: 00 all I/O FFh, 01/10 low, 11 both.
// - Straps are inputs during reset; board sets them with resistors.
// - CPU program segment register is also port 2 configuration two.
// - Output timing bit 1 forces expander outputs high during strobe.
// - Output timing bit 0 selects alternate read/write timing.
// - DMA segment registers and CPU segment registers are all reachable.
// - Stretch pin sampled only when stretch pin enable is set.
// - Bus request floats pins, grant low; drive two cycles before restart.
module ext_mem_stretch (
    input wire logic clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic accessStart,
    input wire logic accessExternal,
    input wire logic [1:0] accessKind,
    input wire logic [15:0] accessAddr,
    input wire logic accessWrite,
    output logic corePhaseEn,
    output logic accessDone,
    output logic [1:0] corePhase,
    input wire logic stretchReqPin,
    input wire logic busRequestPin,
    output logic busGrant_n,
    input wire logic romlessStrapPin,
    input wire logic segHighNibbleStrapPin,
    input wire logic segLowNibbleStrapPin,
    output logic strapInputMode,
    output logic progMemDisable,
    output logic [2:0] portConfig,
    output logic portPushPull,
    output logic busFloat,
    output logic addrStrobePhase,
    output logic altRwTiming,
    output logic [7:0] expanderOut,
    output logic [7:0] expanderEnable,
    output logic watchdogEnable
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [4:0] pinMeta;
    logic [4:0] pinSync;
    // Not reset: straps must reach the capture flop through reset
    always_ff @(posedge clk) begin
        if (clkEn) begin
            pinMeta <= {stretchReqPin, busRequestPin, romlessStrapPin,
                segHighNibbleStrapPin, segLowNibbleStrapPin};
            pinSync <= pinMeta;
        end
    end
    logic stretchLow;
    logic busReqLow;
    assign stretchLow = ~pinSync[4];
    assign busReqLow = ~pinSync[3];

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] stretchCtrl;
    logic [7:0] coreMode;
    logic [7:0] extIntVec;
    logic [7:0] segCpuProg;
    logic [7:0] segCpuData;
    logic [7:0] segDmaProg;
    logic [7:0] segDmaData;
    logic [7:0] outTiming;
    logic wrEn;
    logic rdKnown;
    assign wrEn = psel & penable & pwrite;
    assign pready = 1'b1;

    function automatic logic knownAddr(input logic [11:0] a);
        case (a)
            `ADDR_STRETCH_CTRL, `ADDR_CORE_MODE, `ADDR_EXT_INT_VEC,
            `ADDR_SEG_CPU_PROG, `ADDR_SEG_CPU_DATA, `ADDR_SEG_DMA_PROG,
            `ADDR_SEG_DMA_DATA, `ADDR_OUT_TIMING, `ADDR_STATUS:
                knownAddr = 1'b1;
            default:
                knownAddr = 1'b0;
        endcase
    endfunction
    assign rdKnown = knownAddr(paddr);
    assign pslverr = psel & penable & ~rdKnown;

    always_ff @(posedge clk) begin
        if (rst) begin
            stretchCtrl <= `STRETCH_CTRL_RESET;
            coreMode <= 8'h00;
            extIntVec <= 8'h00;
            segCpuProg <= `SEG_RESET;
            segCpuData <= `SEG_RESET;
            segDmaProg <= `SEG_RESET;
            segDmaData <= `SEG_RESET;
            outTiming <= 8'h00;
        end else if (clkEn && wrEn) begin
            case (paddr)
                `ADDR_STRETCH_CTRL:
                    stretchCtrl <= pwdata[7:0] & `STRETCH_CTRL_MASK;
                `ADDR_CORE_MODE: coreMode <= pwdata[7:0];
                `ADDR_EXT_INT_VEC: extIntVec <= pwdata[7:0];
                `ADDR_SEG_CPU_PROG: segCpuProg <= pwdata[7:0];
                `ADDR_SEG_CPU_DATA: segCpuData <= pwdata[7:0];
                `ADDR_SEG_DMA_PROG: segDmaProg <= pwdata[7:0];
                `ADDR_SEG_DMA_DATA: segDmaData <= pwdata[7:0];
                `ADDR_OUT_TIMING: outTiming <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Straps
    // ------------------------------------------------------------
    logic rstSeen;
    logic strapTaken;
    logic romlessLow;
    logic [1:0] nibbleStrap;
    always_ff @(posedge clk) begin
        if (rst) begin
            rstSeen <= 1'b1;
            strapTaken <= 1'b0;
            romlessLow <= 1'b0;
            nibbleStrap <= 2'h0;
        end else if (clkEn) begin
            rstSeen <= 1'b0;
            if (rstSeen) begin
                strapTaken <= 1'b1;
                romlessLow <= ~pinSync[2];
                nibbleStrap <= pinSync[1:0];
            end
        end
    end
    assign strapInputMode = rst | rstSeen;
    assign progMemDisable = romlessLow;
    assign watchdogEnable = stretchCtrl[6];
    assign altRwTiming = outTiming[0];

    // Reset port mode follows the ROM-less status
    always_comb begin
        if (romlessLow) begin
            portConfig = `PORT_CFG_ROMLESS;
            portPushPull = 1'b1;
        end else begin
            portConfig = `PORT_CFG_ROM;
            portPushPull = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------
    ext_mem_pkg::cycle_type state;
    logic [2:0] waitCount;
    logic [1:0] resumeCount;
    logic [1:0] kind;
    logic [15:0] addrHold;
    logic external;
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= ext_mem_pkg::IDLE_ST;
            waitCount <= 3'h0;
            resumeCount <= 2'h0;
            kind <= 2'h0;
            addrHold <= 16'h0000;
            external <= 1'b0;
        end else if (clkEn) begin
            case (state)
                ext_mem_pkg::IDLE_ST: begin
                    if (busReqLow && coreMode[1]) begin
                        state <= ext_mem_pkg::FLOAT_ST;
                    end else if (accessStart) begin
                        kind <= accessKind;
                        addrHold <= accessAddr;
                        external <= accessExternal | (romlessLow &
                            (accessKind == ext_mem_pkg::CPU_PROG ||
                             accessKind == ext_mem_pkg::DMA_PROG));
                        state <= ext_mem_pkg::T2_ST;
                    end
                end
                ext_mem_pkg::T2_ST: begin
                    if (!external) begin
                        state <= ext_mem_pkg::T3_ST;
                    end else begin
                        if (kind[0]) begin
                            waitCount <= stretchCtrl[5:3];
                        end else begin
                            waitCount <= stretchCtrl[2:0];
                        end
                        state <= ext_mem_pkg::PROG_ST;
                    end
                end
                ext_mem_pkg::PROG_ST: begin
                    if (waitCount != 3'h0) begin
                        waitCount <= waitCount - 3'h1;
                    end else if (extIntVec[0] && stretchLow) begin
                        state <= ext_mem_pkg::PIN_ST;
                    end else begin
                        state <= ext_mem_pkg::T3_ST;
                    end
                end
                ext_mem_pkg::PIN_ST: begin
                    if (!(extIntVec[0] && stretchLow)) begin
                        state <= ext_mem_pkg::T3_ST;
                    end
                end
                ext_mem_pkg::T3_ST: begin
                    state <= ext_mem_pkg::IDLE_ST;
                end
                ext_mem_pkg::FLOAT_ST: begin
                    if (!busReqLow) begin
                        resumeCount <= `BUS_RESUME_CYCLES;
                        state <= ext_mem_pkg::RESUME_ST;
                    end
                end
                ext_mem_pkg::RESUME_ST: begin
                    if (resumeCount == 2'h1) begin
                        state <= ext_mem_pkg::IDLE_ST;
                    end
                    resumeCount <= resumeCount - 2'h1;
                end
                default: state <= ext_mem_pkg::IDLE_ST;
            endcase
        end
    end

    logic stretching;
    assign stretching = state == ext_mem_pkg::PROG_ST ||
        state == ext_mem_pkg::PIN_ST || state == ext_mem_pkg::FLOAT_ST ||
        state == ext_mem_pkg::RESUME_ST;
    assign corePhaseEn = clkEn & ~stretching;
    assign accessDone = state == ext_mem_pkg::T3_ST;
    assign corePhase = (state == ext_mem_pkg::T2_ST) ? 2'h2 :
        (state == ext_mem_pkg::T3_ST) ? 2'h3 :
        (state == ext_mem_pkg::IDLE_ST) ? 2'h1 : 2'h2;
    assign addrStrobePhase = state == ext_mem_pkg::IDLE_ST && accessStart;
    assign busGrant_n = ~(state == ext_mem_pkg::FLOAT_ST);
    assign busFloat = coreMode[0] | state == ext_mem_pkg::FLOAT_ST;

    // ------------------------------------------------------------
    // Bank expander
    // ------------------------------------------------------------
    logic [7:0] segSel;
    logic [7:0] expNext;
    always_comb begin
        case (kind)
            ext_mem_pkg::CPU_PROG: segSel = segCpuProg;
            ext_mem_pkg::CPU_DATA: segSel = segCpuData;
            ext_mem_pkg::DMA_PROG: segSel = segDmaProg;
            default: segSel = segDmaData;
        endcase
        if (!addrHold[15] || state == ext_mem_pkg::IDLE_ST) begin
            expNext = `SEG_RESET;
        end else begin
            expNext = segSel;
        end
        if (outTiming[1] && addrStrobePhase) begin
            expNext = 8'hFF;
        end
        case (nibbleStrap)
            2'h0: expNext = `SEG_IO_VALUE;
            2'h1, 2'h2: expNext = {4'hF, expNext[3:0]};
            default: ;
        endcase
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            expanderOut <= `SEG_RESET;
        end else if (clkEn) begin
            expanderOut <= expNext;
        end
    end
    assign expanderEnable = strapTaken ? (nibbleStrap == 2'h3 ? 8'hFF :
        nibbleStrap == 2'h0 ? 8'h00 : 8'h0F) : 8'h00;

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h00000000;
        end else if (clkEn && psel && !penable) begin
            case (paddr)
                `ADDR_STRETCH_CTRL:
                    prdata <= {24'h0, stretchCtrl & `STRETCH_CTRL_MASK};
                `ADDR_CORE_MODE: prdata <= {24'h0, coreMode};
                `ADDR_EXT_INT_VEC: prdata <= {24'h0, extIntVec};
                `ADDR_SEG_CPU_PROG: prdata <= {24'h0, segCpuProg};
                `ADDR_SEG_CPU_DATA: prdata <= {24'h0, segCpuData};
                `ADDR_SEG_DMA_PROG: prdata <= {24'h0, segDmaProg};
                `ADDR_SEG_DMA_DATA: prdata <= {24'h0, segDmaData};
                `ADDR_OUT_TIMING: prdata <= {24'h0, outTiming};
                `ADDR_STATUS: prdata <= {24'h0, state, nibbleStrap,
                    romlessLow, ~busGrant_n, strapTaken};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_reset_ctrl;
        @(posedge clk) $fell(rst) |-> stretchCtrl == 8'h7F;
    endproperty
    a_reset_ctrl: assert property (p_reset_ctrl) else $error("bad reset");
    property p_bit7;
        @(posedge clk) disable iff (rst) stretchCtrl[7] == 1'b0;
    endproperty
    a_bit7: assert property (p_bit7) else $error("bit7 set");
    property p_internal;
        @(posedge clk) disable iff (rst)
            state == ext_mem_pkg::T2_ST && !external && clkEn
            |=> state == ext_mem_pkg::T3_ST;
    endproperty
    a_internal: assert property (p_internal) else $error("stretched");
    property p_prog_count;
        @(posedge clk) disable iff (rst)
            state == ext_mem_pkg::T2_ST && external && !kind[0] && clkEn
            |=> waitCount == stretchCtrl[2:0];
    endproperty
    a_prog_count: assert property (p_prog_count) else $error("prog count");
    property p_data_count;
        @(posedge clk) disable iff (rst)
            state == ext_mem_pkg::T2_ST && external && kind[0] && clkEn
            |=> waitCount == stretchCtrl[5:3];
    endproperty
    a_data_count: assert property (p_data_count) else $error("data count");
    property p_pin_hold;
        @(posedge clk) disable iff (rst)
            state == ext_mem_pkg::PIN_ST && stretchLow && extIntVec[0]
            |=> state == ext_mem_pkg::PIN_ST;
    endproperty
    a_pin_hold: assert property (p_pin_hold) else $error("pin drop");
    property p_grant;
        @(posedge clk) disable iff (rst)
            state == ext_mem_pkg::FLOAT_ST |-> !busGrant_n && busFloat;
    endproperty
    a_grant: assert property (p_grant) else $error("grant");
    property p_common;
        @(posedge clk) disable iff (rst)
            clkEn && !addrHold[15] && nibbleStrap == 2'h3 && !outTiming[1]
            |=> expanderOut == 8'hFE;
    endproperty
    a_common: assert property (p_common) else $error("common seg");
endmodule

// [tb/ext_mem_partner.sv]
`timescale 1ns/1ps
module ext_mem_partner (
    input wire logic clk,
    input wire logic rst,
    input wire logic accessStart,
    input wire logic accessExternal,
    input wire logic [7:0] waitHold,
    input wire logic busHold,
    output logic stretchReqPin,
    output logic busRequestPin
);
    logic [7:0] holdLeft;
    // ----------------------------------------------------------------
    // Slow memory ready
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            holdLeft <= 8'h00;
        end else if (accessStart && accessExternal) begin
            holdLeft <= waitHold;
        end else if (holdLeft != 8'h00) begin
            holdLeft <= holdLeft - 8'h01;
        end
    end
    // Held low until ready, pulled high once released
    assign stretchReqPin = (holdLeft == 8'h00);
    // ----------------------------------------------------------------
    // Other bus master
    // ----------------------------------------------------------------
    assign busRequestPin = ~busHold;
endmodule

// [tb/tb.sv]
`timescale 1ns/1ps
`include "ext_mem_map.svh"
module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, corePhaseEn, accessDone, busGrant_n;
    logic accessStart = 1'b0;
    logic accessExternal = 1'b0;
    logic [1:0] accessKind = 2'h0;
    logic [15:0] accessAddr = 16'h0000;
    logic [1:0] corePhase;
    logic stretchReqPin, busRequestPin, strapInputMode, progMemDisable;
    logic romless = 1'b1;
    logic segHigh = 1'b1;
    logic segLow = 1'b1;
    logic [2:0] portConfig;
    logic portPushPull, busFloat, addrStrobePhase, altRwTiming;
    logic [7:0] expanderOut, expanderEnable;
    logic watchdogEnable;
    logic [7:0] waitHold = 8'h00;
    logic busHold = 1'b0;
    logic [31:0] rdv;
    logic errv;
    int fails = 0;
    int tests_run = 0;
    int lat, low, c;
    logic [7:0] segVal [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
    logic [7:0] enaExp [4] = '{8'h00, 8'h0F, 8'h0F, 8'hFF};
    always #5 clk = ~clk;
    ext_mem_stretch i_dut (.clk(clk), .rst(rst), .clkEn(1'b1),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .accessStart(accessStart),
        .accessExternal(accessExternal), .accessKind(accessKind),
        .accessAddr(accessAddr), .accessWrite(1'b0),
        .corePhaseEn(corePhaseEn), .accessDone(accessDone),
        .corePhase(corePhase), .stretchReqPin(stretchReqPin),
        .busRequestPin(busRequestPin), .busGrant_n(busGrant_n),
        .romlessStrapPin(romless), .segHighNibbleStrapPin(segHigh),
        .segLowNibbleStrapPin(segLow), .strapInputMode(strapInputMode),
        .progMemDisable(progMemDisable), .portConfig(portConfig),
        .portPushPull(portPushPull), .busFloat(busFloat),
        .addrStrobePhase(addrStrobePhase), .altRwTiming(altRwTiming),
        .expanderOut(expanderOut), .expanderEnable(expanderEnable),
        .watchdogEnable(watchdogEnable));
    ext_mem_partner i_partner (.clk(clk), .rst(rst),
        .accessStart(accessStart), .accessExternal(accessExternal),
        .waitHold(waitHold), .busHold(busHold),
        .stretchReqPin(stretchReqPin), .busRequestPin(busRequestPin));
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task check(input string name, input logic [31:0] exp,
               input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task end_sim;
        if (fails == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task apb(input logic wr, input logic [11:0] addr, input logic [7:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        paddr <= addr;
        pwrite <= wr;
        pwdata <= {24'h0, wd};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task reg_write(input logic [11:0] addr, input logic [7:0] d);
        apb(1'b1, addr, d);
    endtask
    task reg_check(input string name, input logic [11:0] addr,
                   input logic [7:0] exp);
        apb(1'b0, addr, 8'h00);
        check(name, {24'h0, exp}, rdv);
    endtask
    task run_access(input logic ext, input logic [1:0] kind,
                    input logic [15:0] addr);
        accessStart <= 1'b1;
        accessExternal <= ext;
        accessKind <= kind;
        accessAddr <= addr;
        @(posedge clk);
        accessStart <= 1'b0;
        lat = 1;
        low = 0;
        #1;
        while (accessDone !== 1'b1 && lat < 60) begin
            if (corePhaseEn !== 1'b1) low++;
            @(posedge clk);
            #1;
            lat++;
        end
        @(posedge clk);
    endtask
    task apply_reset(input logic [1:0] nib, input logic rom);
        segHigh <= nib[1];
        segLow <= nib[0];
        romless <= rom;
        repeat (3) @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        check("strap mode", 32'h1, {31'h0, strapInputMode});
        rst <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        #200000;
        fails++;
        end_sim;
    end
    initial begin
        for (int i = 0; i < 4; i++) begin
            apply_reset(2'(i), i[0]);
            check("rom off", {31'h0, ~i[0]}, {31'h0, progMemDisable});
            check("port cfg", i[0] ? `PORT_CFG_ROM : `PORT_CFG_ROMLESS,
                  {29'h0, portConfig});
            check("push pull", {31'h0, ~i[0]}, {31'h0, portPushPull});
            check("exp ena", {24'h0, enaExp[i]}, {24'h0, expanderEnable});
            check("exp out", i == 0 ? 32'hFF : 32'hFE, {24'h0, expanderOut});
            check("wdg", 32'h1, {31'h0, watchdogEnable});
            reg_check("ctrl rst", `ADDR_STRETCH_CTRL, 8'h7F);
        end
        reg_write(`ADDR_STRETCH_CTRL, 8'hBF);
        reg_check("ctrl b7", `ADDR_STRETCH_CTRL, 8'h3F);
        check("wdg off", 32'h0, {31'h0, watchdogEnable});
        apb(1'b0, 12'h500, 8'h00);
        check("unmapped err", 32'h1, {31'h0, errv});
        check("unmapped data", 32'h0, rdv);
        reg_write(`ADDR_OUT_TIMING, 8'h01);
        check("alt rw", 32'h1, {31'h0, altRwTiming});
        reg_write(`ADDR_OUT_TIMING, 8'h00);
        for (int n = 0; n < 8; n++) begin
            reg_write(`ADDR_STRETCH_CTRL, 8'((7 - n) * 8 + n));
            run_access(1'b1, 2'h0, 16'h0100);
            check("prog lat", 32'(3 + n), 32'(lat));
            run_access(1'b1, 2'h1, 16'h0100);
            check("data lat", 32'(10 - n), 32'(lat));
        end
        run_access(1'b0, 2'h1, 16'h0100);
        check("int lat", 32'h2, 32'(lat));
        check("int low", 32'h0, 32'(low));
        reg_write(`ADDR_STRETCH_CTRL, 8'h00);
        waitHold <= 8'h0A;
        run_access(1'b1, 2'h0, 16'h0100);
        check("pin off", 32'h3, 32'(lat));
        reg_write(`ADDR_EXT_INT_VEC, 8'h01);
        run_access(1'b1, 2'h0, 16'h0100);
        check("pin lat", 32'h1, {31'h0, lat > 9 && lat < 17});
        reg_write(`ADDR_STRETCH_CTRL, 8'h02);
        run_access(1'b1, 2'h0, 16'h0100);
        check("both lat", 32'h1, {31'h0, lat > 9 && lat < 17});
        waitHold <= 8'h00;
        for (int k = 0; k < 4; k++) begin
            reg_write(12'(`ADDR_SEG_CPU_PROG + 4 * k), segVal[k]);
            reg_check("seg rd", 12'(`ADDR_SEG_CPU_PROG + 4 * k), segVal[k]);
        end
        for (int k = 0; k < 4; k++) begin
            run_access(1'b1, 2'(k), 16'h8000);
            check("seg out", {24'h0, segVal[k]}, {24'h0, expanderOut});
            run_access(1'b1, 2'(k), 16'h7FFF);
            check("common", 32'hFE, {24'h0, expanderOut});
        end
        reg_write(`ADDR_CORE_MODE, 8'h01);
        check("float", 32'h1, {31'h0, busFloat});
        check("no grant", 32'h1, {31'h0, busGrant_n});
        run_access(1'b0, 2'h0, 16'h0100);
        check("float int", 32'h2, 32'(lat));
        reg_write(`ADDR_CORE_MODE, 8'h02);
        check("unfloat", 32'h0, {31'h0, busFloat});
        busHold <= 1'b1;
        c = 0;
        while (busGrant_n !== 1'b0 && c < 20) begin
            @(posedge clk);
            #1;
            c++;
        end
        check("grant", 32'h1, {31'h0, busFloat});
        busHold <= 1'b0;
        c = 0;
        while (busFloat !== 1'b0 && c < 20) begin
            @(posedge clk);
            #1;
            c++;
        end
        c = 0;
        while (corePhaseEn !== 1'b1 && c < 20) begin
            @(posedge clk);
            #1;
            c++;
        end
        check("resume", 32'(`BUS_RESUME_CYCLES), 32'(c));
        end_sim;
    end
endmodule
